// ### logic/adcseq_pkg.sv
// Shared constants and types for the conversion sequencer.
package adcseq_pkg;

    // ****************************************************************
    // Register map and fields
    // ****************************************************************
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_RESULT = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;

    localparam int POS_MODE    = 0;
    localparam int POS_TRIG    = 1;
    localparam int POS_INSEL   = 4;
    localparam int POS_RANGE   = 8;
    localparam int POS_RATE    = 12;

    localparam logic       RST_MODE  = 1'b1;
    localparam logic [2:0] RST_INSEL = 3'h0;
    localparam logic [2:0] RST_RANGE = 3'h2;
    localparam logic [2:0] RST_RATE  = 3'h4;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int PCLK_HZ      = 25_000_000;
    localparam int OSC_HZ       = 1_000_000;
    localparam int OSC_DIV      = PCLK_HZ / OSC_HZ;
    localparam int MOD_DIV      = 4;
    localparam int MOD_HZ       = OSC_HZ / MOD_DIV;
    localparam int WAKE_US      = 25;
    localparam logic [4:0] WAKE_TICKS = 5'(WAKE_US * OSC_HZ / 1_000_000);

    // Modulator cycles per conversion for each data rate (8 .. 860 per second).
    localparam logic [14:0] RATE_LEN [8] = '{
        15'(MOD_HZ / 8),   15'(MOD_HZ / 16),  15'(MOD_HZ / 32),  15'(MOD_HZ / 64),
        15'(MOD_HZ / 128), 15'(MOD_HZ / 250), 15'(MOD_HZ / 475), 15'(MOD_HZ / 860)};

    // ****************************************************************
    // Full-scale spans in millivolts and the range used without a gain stage
    // ****************************************************************
    localparam logic [12:0] SPAN_MV [8] = '{
        13'd6144, 13'd4096, 13'd2048, 13'd1024, 13'd512, 13'd256, 13'd256, 13'd256};
    localparam logic [2:0]  FIXED_RANGE = 3'h2;

    typedef enum logic [1:0] {
        ADCSEQ_OFF  = 2'b00,
        ADCSEQ_WAKE = 2'b01,
        ADCSEQ_CONV = 2'b11
    } adcseq_state_t;

    // Analog front-end controls.
    typedef struct packed {
        logic [3:0]  positive_input;
        logic [3:0]  negative_input;
        logic        negative_to_ground;
        logic [2:0]  gain_stage;
        logic [12:0] full_scale_span_mv;
        logic [27:0] lsb_pv;
        logic        sample_switch;
        logic        discharge_switch;
    } adcseq_afe_t;

endpackage : adcseq_pkg

// ### logic/adcseq_top.sv
// Conversion sequencer with APB register access around a delta-sigma core.
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
// What this block does
// RULE1 - Single-shot: one conversion, store, power down
// RULE2 - Continuous: restart right after each conversion
// RULE3 - Continuous completion rate equals selected rate
// RULE4 - Result always holds last complete conversion
// RULE5 - Input field routes four single or four pairs
// RULE6 - Inputs 0, 1 or 2 against input 3
// RULE7 - Single-ended selection grounds negative input
// RULE8 - No multiplexer: input 0 minus input 1
// RULE9 - Range field picks one of six spans
// RULE10 - Code weight is span over 2^16
// RULE11 - No gain stage: fixed 2.048 V span
// RULE12 - Modulator rate is oscillator divided by four
// RULE13 - All timing from internal oscillator only
// RULE14 - Rates and times divide the oscillator
// RULE15 - Sample opens before discharge closes, no overlap
// RULE16 - Mode bit: 1 single-shot, 0 continuous
// RULE17 - Trigger: wake 25 us, clear bit, convert
// RULE18 - Trigger ignored while conversion in progress
// RULE19 - Rate field: eight rates, settle in one period
// RULE20 - Result register loads in one cycle
module adcseq_top #(
    parameter bit HAS_MUX  = 1'b1,
    parameter bit HAS_GAIN = 1'b1,
    parameter int OSC_DIV  = adcseq_pkg::OSC_DIV
) (
    // Clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Decimation filter
    input  wire logic [15:0]         filter_code,
    output logic                     filter_clear,
    output logic                     filter_run,
    output logic                     modulator_rate,
    // Analog front end
    output adcseq_pkg::adcseq_afe_t  afe
);

    // ****************************************************************
    // Registers and state
    // ****************************************************************
    logic                      mode;
    logic                      trig;
    logic [2:0]                input_select_field;
    logic [2:0]                range_select_field;
    logic [2:0]                rate_select_field;
    logic [15:0]               result;
    logic [2:0]                act_insel;
    logic [2:0]                act_range;
    logic [2:0]                act_rate;
    adcseq_pkg::adcseq_state_t state;
    logic [$clog2(OSC_DIV)-1:0] osc_cnt;
    logic                      osc_tick;
    logic [1:0]                mod_phase;
    logic [4:0]                wake_cnt;
    logic [14:0]               conv_cnt;
    logic                      wr_en;
    logic                      rd_en;
    logic                      conv_end;
    logic [2:0]                eff_range;
    logic [3:0]                next_pos;
    logic [3:0]                next_neg;
    logic                      next_gnd;
    logic [31:0]               next_rdata;
    logic                      next_err;

    assign wr_en = psel & penable & pready & pwrite;
    assign rd_en = psel & penable & ~pready;

    // ****************************************************************
    // Timebase
    // ****************************************************************
    // The 1 MHz oscillator is modelled as an enable from pclk; nothing else sets timing.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_cnt  <= '0;
            osc_tick <= 1'b0;
        end else begin
            osc_tick <= (osc_cnt == ($clog2(OSC_DIV))'(OSC_DIV - 1)); // [RULE13]
            if (osc_cnt == ($clog2(OSC_DIV))'(OSC_DIV - 1)) begin
                osc_cnt <= '0;
            end else begin
                osc_cnt <= osc_cnt + 1'b1;
            end
        end
    end

    // Four oscillator ticks form one modulator cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mod_phase      <= 2'h0;
            modulator_rate <= 1'b0;
        end else begin
            if (osc_tick) begin
                mod_phase <= mod_phase + 2'h1; // [RULE12]
            end
            modulator_rate <= osc_tick && (mod_phase == 2'(adcseq_pkg::MOD_DIV - 1)); // [RULE12]
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    assign conv_end = (state == adcseq_pkg::ADCSEQ_CONV) && modulator_rate
                      && (conv_cnt == 15'h0001);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= adcseq_pkg::ADCSEQ_OFF;
            wake_cnt  <= 5'h00;
            conv_cnt  <= 15'h0000;
            act_insel <= adcseq_pkg::RST_INSEL;
            act_range <= adcseq_pkg::RST_RANGE;
            act_rate  <= adcseq_pkg::RST_RATE;
        end else begin
            case (state)
                adcseq_pkg::ADCSEQ_OFF: begin
                    if (!mode || trig) begin // [RULE16]
                        state    <= adcseq_pkg::ADCSEQ_WAKE;
                        wake_cnt <= adcseq_pkg::WAKE_TICKS; // [RULE17]
                    end
                end
                adcseq_pkg::ADCSEQ_WAKE: begin
                    if (osc_tick) begin
                        wake_cnt <= wake_cnt - 5'h01;
                    end
                    if (osc_tick && wake_cnt == 5'h01 && modulator_rate == 1'b0) begin
                        state     <= adcseq_pkg::ADCSEQ_CONV; // [RULE17]
                        act_insel <= input_select_field;
                        act_range <= range_select_field;
                        act_rate  <= rate_select_field;
                        conv_cnt  <= adcseq_pkg::RATE_LEN[rate_select_field]; // [RULE19]
                    end
                end
                adcseq_pkg::ADCSEQ_CONV: begin
                    if (modulator_rate) begin
                        conv_cnt <= conv_cnt - 15'h0001; // [RULE14]
                    end
                    if (conv_end) begin
                        if (mode) begin
                            state <= adcseq_pkg::ADCSEQ_OFF; // [RULE1]
                        end else begin
                            // New settings apply only from the next conversion on.
                            act_insel <= input_select_field; // [RULE2]
                            act_range <= range_select_field;
                            act_rate  <= rate_select_field;
                            conv_cnt  <= adcseq_pkg::RATE_LEN[rate_select_field]; // [RULE3]
                        end
                    end
                end
                default: begin
                    state <= adcseq_pkg::ADCSEQ_OFF;
                end
            endcase
        end
    end

    // Filter handshake: cleared at every conversion start, run while converting.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filter_clear <= 1'b0;
            filter_run   <= 1'b0;
        end else begin
            filter_clear <= (state == adcseq_pkg::ADCSEQ_WAKE && osc_tick && wake_cnt == 5'h01)
                            || (conv_end && !mode); // [RULE2]
            filter_run   <= (state == adcseq_pkg::ADCSEQ_CONV) && !(conv_end && mode);
        end
    end

    // The whole word loads at once, so a read never sees two conversions mixed.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result <= 16'h0000;
        end else if (conv_end) begin
            result <= filter_code; // [RULE20] [RULE4] [RULE10]
        end
    end

    // ****************************************************************
    // Analog front end
    // ****************************************************************
    always_comb begin
        next_pos = 4'h1;
        next_neg = 4'h2;
        next_gnd = 1'b0;
        if (HAS_MUX) begin
            case (act_insel) // [RULE5]
                3'h0: begin next_pos = 4'h1; next_neg = 4'h2; end
                3'h1: begin next_pos = 4'h1; next_neg = 4'h8; end // [RULE6]
                3'h2: begin next_pos = 4'h2; next_neg = 4'h8; end // [RULE6]
                3'h3: begin next_pos = 4'h4; next_neg = 4'h8; end
                3'h4: begin next_pos = 4'h1; next_neg = 4'h0; next_gnd = 1'b1; end // [RULE7]
                3'h5: begin next_pos = 4'h2; next_neg = 4'h0; next_gnd = 1'b1; end // [RULE7]
                3'h6: begin next_pos = 4'h4; next_neg = 4'h0; next_gnd = 1'b1; end // [RULE7]
                3'h7: begin next_pos = 4'h8; next_neg = 4'h0; next_gnd = 1'b1; end // [RULE7]
                default: begin next_pos = 4'h1; next_neg = 4'h2; end
            endcase
        end
    end

    // Codes 5 to 7 all give the smallest span.
    assign eff_range = HAS_GAIN ? act_range : adcseq_pkg::FIXED_RANGE; // [RULE11] [RULE9]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            afe.positive_input     <= 4'h0;
            afe.negative_input     <= 4'h0;
            afe.negative_to_ground <= 1'b0;
        end else begin
            afe.positive_input     <= next_pos; // [RULE8]
            afe.negative_input     <= next_neg; // [RULE8]
            afe.negative_to_ground <= next_gnd; // [RULE7]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            afe.gain_stage         <= adcseq_pkg::RST_RANGE;
            afe.full_scale_span_mv <= adcseq_pkg::SPAN_MV[adcseq_pkg::RST_RANGE];
            afe.lsb_pv             <= 28'h0000000;
        end else begin
            afe.gain_stage         <= eff_range; // [RULE9]
            afe.full_scale_span_mv <= adcseq_pkg::SPAN_MV[eff_range]; // [RULE9]
            // Span in pV is mV * 1e9; dividing by 2^16 gives one code step.
            afe.lsb_pv <= 28'((64'(adcseq_pkg::SPAN_MV[eff_range]) * 64'd1_000_000_000)
                              >> 16); // [RULE10]
        end
    end

    // Phases 0-1 sample, phase 2 all open, phase 3 discharge: a dead time between.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            afe.sample_switch    <= 1'b0;
            afe.discharge_switch <= 1'b0;
        end else begin
            afe.sample_switch    <= (state == adcseq_pkg::ADCSEQ_CONV)
                                    && (mod_phase[1] == 1'b0); // [RULE15]
            afe.discharge_switch <= (state == adcseq_pkg::ADCSEQ_CONV)
                                    && (mod_phase == 2'h3); // [RULE15]
        end
    end

    // ****************************************************************
    // Register file
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode               <= adcseq_pkg::RST_MODE;
            input_select_field <= adcseq_pkg::RST_INSEL;
            range_select_field <= adcseq_pkg::RST_RANGE;
            rate_select_field  <= adcseq_pkg::RST_RATE;
        end else if (wr_en && paddr == adcseq_pkg::OFS_CTRL) begin
            mode               <= pwdata[adcseq_pkg::POS_MODE]; // [RULE16]
            input_select_field <= pwdata[adcseq_pkg::POS_INSEL +: 3];
            range_select_field <= pwdata[adcseq_pkg::POS_RANGE +: 3];
            rate_select_field  <= pwdata[adcseq_pkg::POS_RATE +: 3]; // [RULE19]
        end
    end

    // Trigger is accepted only when idle in single-shot mode and self-clears at start.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig <= 1'b0;
        end else if (state == adcseq_pkg::ADCSEQ_WAKE && osc_tick && wake_cnt == 5'h01) begin
            trig <= 1'b0; // [RULE17]
        end else if (wr_en && paddr == adcseq_pkg::OFS_CTRL && pwdata[adcseq_pkg::POS_TRIG]
                     && pwdata[adcseq_pkg::POS_MODE] && state == adcseq_pkg::ADCSEQ_OFF) begin
            trig <= 1'b1; // [RULE18]
        end
    end

    always_comb begin
        next_rdata = 32'h00000000;
        next_err   = 1'b0;
        case (paddr)
            adcseq_pkg::OFS_CTRL: begin
                next_rdata[adcseq_pkg::POS_MODE]     = mode;
                next_rdata[adcseq_pkg::POS_TRIG]     = trig;
                next_rdata[adcseq_pkg::POS_INSEL +: 3] = input_select_field;
                next_rdata[adcseq_pkg::POS_RANGE +: 3] = range_select_field;
                next_rdata[adcseq_pkg::POS_RATE +: 3]  = rate_select_field;
            end
            adcseq_pkg::OFS_RESULT: begin
                next_rdata[15:0] = result; // [RULE4]
            end
            adcseq_pkg::OFS_STATUS: begin
                next_rdata[1:0]  = state;
                next_rdata[6:4]  = act_rate;
                next_rdata[10:8] = act_insel;
            end
            default: begin
                next_err = 1'b1;
            end
        endcase
    end

    // One wait state: pready is registered, so it is low in the first access cycle and rises in the second, which ends the transfer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready  <= rd_en;
            pslverr <= rd_en & next_err;
            prdata  <= (rd_en && !pwrite) ? next_rdata : 32'h00000000;
        end
    end

endmodule : adcseq_top

// ### test/adcseq_filter_model.sv
// Decimation filter model that hands one chosen code per conversion.
`timescale 1ns/10ps
module adcseq_filter_model (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Code chosen by the bench for the next conversion
    input wire logic [15:0] seed,
    // Sequencer side
    input wire logic        filter_clear,
    input wire logic        filter_run,
    output logic     [15:0] filter_code
);
    logic [15:0] hold;
    // Outside a conversion the code toggles every cycle, so an early or late capture shows.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold        <= 16'h0000;
            filter_code <= 16'h5A5A;
        end else begin
            hold        <= filter_clear ? seed : hold;
            filter_code <= filter_run ? hold : ~filter_code;
        end
    end
endmodule : adcseq_filter_model

// ### test/adcseq_top_assertions.sv
// Concurrent checks on the conversion sequencer ports.
`timescale 1ns/10ps
module adcseq_top_assertions #(
    parameter int OSC_DIV = 1
) (
    // Clock and reset
    input wire logic                    pclk,
    input wire logic                    presetn,
    // APB answer
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic [31:0]             prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    // Filter and front end
    input wire logic                    filter_clear,
    input wire logic                    filter_run,
    input wire logic                    modulator_rate,
    input wire adcseq_pkg::adcseq_afe_t afe
);
    localparam int MODP = 4 * OSC_DIV;
    logic [15:0] gap;
    logic        whole;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // The gap is trusted only when a conversion ran through it, since a restart may realign it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap   <= 16'h0000;
            whole <= 1'b0;
        end else begin
            gap   <= modulator_rate ? 16'h0000 : gap + 16'h0001;
            whole <= modulator_rate ? filter_run : whole & filter_run;
        end
    end
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    AST_ONE_WAIT: assert property (s_access |=> s_answer)
        else $error("pready did not pulse once after one wait state");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("pslverr outside the answer cycle");
    AST_IDLE_RDATA: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data not zero outside the answer cycle");
    AST_NO_OVERLAP: assert property (
        !(afe.sample_switch && afe.discharge_switch))
        else $error("sample and discharge switches closed together");
    AST_OPEN_FIRST: assert property (
        $rose(afe.discharge_switch) |-> !$past(afe.sample_switch))
        else $error("discharge closed straight after sampling");
    AST_GROUND: assert property (
        afe.negative_to_ground |-> afe.negative_input == 4'h0 && $onehot(afe.positive_input))
        else $error("grounded negative input still routed");
    AST_MOD_DIV: assert property (
        modulator_rate && whole && filter_run |-> gap == 16'(MODP - 1))
        else $error("modulator period differs from four oscillator ticks");
    AST_START: assert property (filter_clear |=> !filter_clear && filter_run)
        else $error("conversion start not followed by a running filter");
    AST_SPAN: assert property (
        $stable(afe.gain_stage) |-> afe.full_scale_span_mv == adcseq_pkg::SPAN_MV[afe.gain_stage])
        else $error("span does not match range code");
    AST_LSB: assert property (
        $stable(afe.full_scale_span_mv) && $past(presetn, 2)
        |-> afe.lsb_pv == 28'((64'(afe.full_scale_span_mv) * 64'h3B9A_CA00) >> 16))
        else $error("code weight is not span over two to the sixteen");
endmodule : adcseq_top_assertions
bind adcseq_top adcseq_top_assertions #(.OSC_DIV(OSC_DIV)) i_adcseq_top_assertions (
    .pclk, .presetn, .psel, .penable, .prdata, .pready, .pslverr,
    .filter_clear, .filter_run, .modulator_rate, .afe);

// ### test/testbench.sv
// Self-checking bench for the conversion sequencer with a filter model.
`timescale 1ns/10ps
module testbench;
    // Two pclk per oscillator tick keeps the tick and the modulator pulse in separate cycles.
    localparam int OSC_DIV = 2;
    logic                    pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]              paddr;
    logic [31:0]             pwdata, prdata, cfg;
    logic [15:0]             filter_code, seed, sd, lfsr_st;
    logic                    filter_clear, filter_run, modulator_rate;
    logic [3:0]              pos;
    logic [12:0]             span;
    logic [52:0]             ea;
    adcseq_pkg::adcseq_afe_t afe;
    logic [32:0]             exp_q[$], msk_q[$];
    int                      error_cnt, checks, cyc, last_clr, last_gap;
    logic [12:0]             spans [8] = '{13'h1800, 13'h1000, 13'h0800, 13'h0400,
                                           13'h0200, 13'h0100, 13'h0100, 13'h0100};
    adcseq_top #(.OSC_DIV(OSC_DIV)) i_adcseq_top (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .filter_code, .filter_clear, .filter_run, .modulator_rate, .afe);
    adcseq_filter_model i_adcseq_filter_model (
        .pclk, .presetn, .seed, .filter_clear, .filter_run, .filter_code);
    always #20 pclk = ~pclk;
    // ********************
    // Shared tasks
    // ********************
    function automatic logic [15:0] lfsr();
        lfsr_st = {lfsr_st[14:0], lfsr_st[15] ^ lfsr_st[13] ^ lfsr_st[12] ^ lfsr_st[10]};
        return lfsr_st;
    endfunction : lfsr
    task automatic chk(input string what, input logic [63:0] e, input logic [63:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic finish_test();
        if (error_cnt == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test
    // Waits for the start pulse (clr high) or for the run level to reach v.
    task automatic wt(input logic clr, input logic v);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while ((clr ? filter_clear : filter_run) !== v && n < 20000);
        if (n >= 20000) begin
            chk("wait", 64'(v), 64'(~v));
            finish_test();
        end
    endtask : wt
    // One transfer, then an idle cycle so no strobe is driven twice in one step.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e, input logic [32:0] m);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        if (!w) begin
            exp_q.push_back(e & m);
            msk_q.push_back(m);
        end
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk("pready", 64'h1, 64'h0);
            finish_test();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (filter_clear === 1'b1) begin
            last_gap <= cyc - last_clr;
            last_clr <= cyc;
        end
        if (psel && penable && !pwrite && pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("queue", 64'h1, 64'h0);
            end else begin
                chk("read", 64'(exp_q.pop_front()), 64'({pslverr, prdata} & msk_q.pop_front()));
            end
        end
    end
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata, seed} = '0;
        {error_cnt, checks, cyc, last_clr, last_gap} = '0;
        lfsr_st = 16'h6282;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, adcseq_pkg::OFS_CTRL, 32'h0, 33'h0_0000_4201, '1);
        apb(1'b0, adcseq_pkg::OFS_RESULT, 32'h0, 33'h0, '1);
        apb(1'b0, 8'h0C, 32'h0, 33'h1_0000_0000, '1);
        for (int i = 0; i < 8; i++) begin
            sd = lfsr();
            seed <= sd;
            cfg = 32'h0000_7003 | 32'(i << 8) | 32'(i << 4);
            apb(1'b1, adcseq_pkg::OFS_CTRL, cfg, 33'h0, 33'h0);
            apb(1'b0, adcseq_pkg::OFS_CTRL, 32'h0, {1'b0, cfg}, '1);
            wt(1'b0, 1'b1);
            apb(1'b1, adcseq_pkg::OFS_CTRL, cfg, 33'h0, 33'h0);
            apb(1'b0, adcseq_pkg::OFS_STATUS, 32'h0, {1'b0, 32'h73 | 32'(i << 8)},
                33'h1_0000_0773);
            pos = (i < 2) ? 4'h1 : 4'(1 << ((i < 4) ? i - 1 : i - 4));
            span = spans[i];
            ea = {pos, ((i == 0) ? 4'h2 : ((i < 4) ? 4'h8 : 4'h0)), i > 3, 3'(i), span,
                  28'((64'(span) * 64'h3B9A_CA00) >> 16)};
            chk("afe", 64'(ea), 64'(afe[54:2]));
            wt(1'b0, 1'b0);
            apb(1'b0, adcseq_pkg::OFS_STATUS, 32'h0, 33'h0, 33'h3);
            apb(1'b0, adcseq_pkg::OFS_RESULT, 32'h0, {17'h0, sd}, '1);
        end
        sd = lfsr();
        seed <= sd;
        apb(1'b1, adcseq_pkg::OFS_CTRL, 32'h0000_7000, 33'h0, 33'h0);
        // The first conversion after wake is not aligned to the modulator, so time the second.
        repeat (3) wt(1'b1, 1'b1);
        @(posedge pclk);
        chk("gap", 64'(adcseq_pkg::MOD_HZ / 860 * 4 * OSC_DIV), 64'(last_gap));
        apb(1'b1, adcseq_pkg::OFS_CTRL, 32'h0000_6000, 33'h0, 33'h0);
        wt(1'b1, 1'b1);
        @(posedge pclk);
        chk("gap", 64'(adcseq_pkg::MOD_HZ / 860 * 4 * OSC_DIV), 64'(last_gap));
        wt(1'b1, 1'b1);
        @(posedge pclk);
        chk("gap", 64'(adcseq_pkg::MOD_HZ / 475 * 4 * OSC_DIV), 64'(last_gap));
        apb(1'b1, adcseq_pkg::OFS_CTRL, 32'h0000_6001, 33'h0, 33'h0);
        wt(1'b0, 1'b0);
        apb(1'b0, adcseq_pkg::OFS_RESULT, 32'h0, {17'h0, sd}, '1);
        apb(1'b0, adcseq_pkg::OFS_STATUS, 32'h0, 33'h0, 33'h3);
        finish_test();
    end
endmodule : testbench
